// File: bench/adc_offset_cal_status_regs_tb.sv
// Self-checking bench for the offset/calibration register bank.
// Assumes the PLL model on the done pin and a 100 MHz clock.
`timescale 1ns/1ps
`include "aoc_defines.vh"
module adc_offset_cal_status_regs_tb;
  localparam [15:0] ID = 16'hc3a5;  // Arbitrary value
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pll_done, drift_lo;
  logic        drift_hi, launch, bg_upd, cal_done, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] smp_in, smp_out;
  logic [15:0] v [0:31];
  logic [7:0]  code;
  int          num_errors, tests_run, i, k, l;

  aoc_regs #(.ID_CODE(ID), .CAL_CYCLES(32'd50), .BG_CYCLES(32'd20)) i_dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_in(smp_in), .sample_out(smp_out), .pll_cal_done_pin(pll_done),
    .pll_drift_low_pin(drift_lo), .pll_drift_high_pin(drift_hi),
    .pll_calibration_launch(launch), .bg_cal_update(bg_upd),
    .adc_cal_done(cal_done), .irq(irq));
  aoc_pll_model #(.LOCK_CYC(16)) i_pll (
    .clk(clk), .rst(rst), .launch(launch), .done(pll_done));

  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Input plus scaled signed offset, offset in quarter steps
  function automatic [15:0] expo(input [15:0] x, input [7:0] c,
                                 input [1:0] w);
    logic signed [31:0] o;
    o = $signed({{24{c[7]}}, c}) <<< w;
    expo = x + o[17:2];
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Write: both halves offered together, each released when taken
  task automatic wr(input [9:0] ix, input [7:0] d, output [1:0] r);
    logic a, w, b;
    @(posedge clk);
    awaddr <= {ix, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      a = awready && awvalid;
      w = wready && wvalid;
      b = bvalid;
      r = bresp;
      @(posedge clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
  endtask
  task automatic rdr(input [9:0] ix, output [31:0] d, output [1:0] r);
    logic a, b;
    @(posedge clk);
    araddr <= {ix, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      a = arready && arvalid;
      b = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (a) arvalid <= 1'b0;
    end while (!b);
    rready <= 1'b0;
  endtask
  task automatic wrc(input [9:0] ix, input [7:0] d);
    wr(ix, d, rs);
    chk({30'h0, rs}, {30'h0, `AOC_RESP_OKAY});
  endtask
  task automatic rc(input [9:0] ix, input [31:0] m, input [31:0] e);
    rdr(ix, rd, rs);
    chk(rd & m, e);
    chk({30'h0, rs}, {30'h0, `AOC_RESP_OKAY});
  endtask

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb, smp_in} = 76'h0;
    {drift_lo, drift_hi} = 2'b00;
    seed = 32'h3578d638;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc(10'h0c0, 32'hff, 32'h00);
    rc(10'h0a5, 32'hff, 32'h00);
    rc(10'h0a7, 32'hff, 32'h47);
    rc(10'h15c, 32'hff, {24'h0, ID[7:0]});
    rc(10'h15d, 32'hff, {24'h0, ID[15:8]});
    wrc(10'h15c, 8'hff);
    wrc(10'h0c0, 8'hff);
    rc(10'h15c, 32'hff, {24'h0, ID[7:0]});
    rc(10'h0c0, 32'hff, 32'h00);
    wr(10'h0a6, 8'h55, rs);
    chk({30'h0, rs}, {30'h0, `AOC_RESP_SLVERR});
    rdr(10'h0a6, rd, rs);
    chk(rd, 32'h0);
    chk({30'h0, rs}, {30'h0, `AOC_RESP_SLVERR});
    k = 0;
    while (cal_done !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    rc(10'h0c0, 32'h80, 32'h80);
    // Offset path over every weight, post-processing off and on
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      code = (k == 0) ? 8'h80 : (k == 1) ? 8'hff : seed[7:0];
      wrc(10'h0a5, code);
      wrc(10'h0a7, 8'h47 & 8'he7 | {3'h0, k[1:0], 3'h0});
      wrc(10'h180, {7'h0, k[2]});
      rc(10'h0a5, 32'hff, {24'h0, code});
      l = k[2] ? 8 : 6;
      for (i = 0; i < 24; i++) begin
        @(posedge clk);
        seed = lfsr(seed);
        v[i] = seed[15:0];
        smp_in <= v[i];
        @(negedge clk);
        if (i >= l)
          chk({16'h0, smp_out}, {16'h0, expo(v[i - l], code, k[1:0])});
      end
    end
    // PLL status, relaunch and drift flags
    rc(10'h0d1, 32'h26, 32'h20);
    wrc(10'h06b, 8'h01);
    rc(10'h0d1, 32'h20, 32'h00);
    repeat (30) @(posedge clk);
    rc(10'h0d1, 32'h20, 32'h20);
    for (k = 0; k < 4; k++) begin
      {drift_hi, drift_lo} <= k[1:0];
      repeat (4) @(posedge clk);
      rc(10'h0d1, 32'h06, {29'h0, k[0], k[1], 1'b0});
    end
    // Interrupt: status, mask, clear
    rc(10'h181, 32'h0f, 32'h0f);
    wrc(10'h181, 8'h1f);
    rc(10'h181, 32'h0f, 32'h00);
    wrc(10'h182, 8'h10);
    k = 0;
    while (irq !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    chk({31'h0, irq}, 32'h1);
    wrc(10'h181, 8'h10);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wrc(10'h182, 8'h00);
    // Second reset mid-run
    rst <= 1'b1;
    @(negedge clk);
    chk({31'h0, cal_done}, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    rc(10'h0a5, 32'hff, 32'h00);
    end_sim();
  end
endmodule

// File: bench/aoc_pll_model.sv
// PLL model driving the calibration-done status pin.
// Assumes launch is a one-cycle pulse on clk.
`timescale 1ns/1ps
module aoc_pll_model #(
  parameter LOCK_CYC = 16
) (
  input  logic clk,
  input  logic rst,
  input  logic launch,
  output logic done
);
  logic [7:0] cnt_r;
  // Relock countdown, restarted at power-up and by each launch
  always @(posedge clk or posedge rst) begin
    if (rst)
      cnt_r <= 8'(LOCK_CYC);
    else if (launch)
      cnt_r <= 8'(LOCK_CYC);
    else if (cnt_r != 8'h0)
      cnt_r <= cnt_r - 8'h1;
  end
  assign done = (cnt_r == 8'h0);
endmodule

// File: bench/aoc_regs_sva.sv
// Bus and status checks for the offset/calibration register bank.
// Assumes it is bound into aoc_regs and sees only that module's ports.
`timescale 1ns/1ps
module aoc_regs_chk #(
  parameter [31:0] CAL_CYCLES = 32'd50
) (
  input logic        clk,
  input logic        rst,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic        pll_calibration_launch,
  input logic        bg_cal_update,
  input logic        adc_cal_done
);
  logic [31:0] cnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Edges since reset release, saturating at the calibration length
  always @(posedge clk or posedge rst) begin
    if (rst)
      cnt_r <= 32'h0;
    else if (cnt_r < CAL_CYCLES)
      cnt_r <= cnt_r + 32'h1;
  end
  // Bus answers hold until taken
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid not released");
  a_rdata_byte: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits");
  // Status flags
  a_cal_timing: assert property (
    adc_cal_done == (cnt_r >= CAL_CYCLES)) else $error("cal done timing");
  a_cal_sticky: assert property (
    adc_cal_done |=> adc_cal_done) else $error("cal done cleared");
  a_launch_pulse: assert property (
    $rose(pll_calibration_launch) |=> !pll_calibration_launch)
    else $error("launch not a pulse");
  a_bg_after_cal: assert property (
    bg_cal_update |-> adc_cal_done ##1 !bg_cal_update)
    else $error("background update misplaced");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (s_axi_rvalid && s_axi_rdata[7]);
  c_launch: cover property (pll_calibration_launch);
  c_bg: cover property (bg_cal_update);
endmodule

bind aoc_regs aoc_regs_chk #(.CAL_CYCLES(CAL_CYCLES)) i_chk (
  .clk(clk), .rst(rst), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata),
  .pll_calibration_launch(pll_calibration_launch),
  .bg_cal_update(bg_cal_update), .adc_cal_done(adc_cal_done)
);

// File: design/aoc_defines.vh
// Constants shared by the ADC offset, calibration and status register bank.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses = 4 x index.
// Notes on behaviour
// - Channel 7 offset code, 8-bit, resets zero
// - Offset code is signed two's complement
// - Weight field bits 4-3 select scale
// - One weight setting serves every offset
// - ADC calibration done flag at bit 7
// - Reserved status bits read-only, no effect
// - PLL calibration complete flag at bit 5
// - Low-frequency drift flag at bit 2
// - High-frequency drift flag at bit 1
// - PLL done flag follows launch bit
// - 16-bit identity code over two bytes
// - Power-up calibration ends within fixed cycles
// - Background calibration updates every fixed period
// - One output sample per clock, fixed latency
// - Post-processing lengthens output latency
`ifndef AOC_DEFINES_VH
`define AOC_DEFINES_VH

// Register indices (byte address is four times the index)
`define AOC_IDX_CH7_OFS    10'h0a5
`define AOC_IDX_WEIGHT     10'h0a7
`define AOC_IDX_CAL_STAT   10'h0c0
`define AOC_IDX_PLL_STAT   10'h0d1
`define AOC_IDX_ID_LO      10'h15c
`define AOC_IDX_ID_HI      10'h15d
`define AOC_IDX_PLL_CTRL   10'h06b
`define AOC_IDX_DSP_CTRL   10'h180
`define AOC_IDX_IRQ_STAT   10'h181
`define AOC_IDX_IRQ_MASK   10'h182

// Reset values
`define AOC_RST_CH7_OFS    8'h00
`define AOC_RST_WEIGHT     8'h47
`define AOC_RST_ZERO8      8'h00
`define AOC_RST_IRQ        5'h00

// Field positions
`define AOC_WGT_HI         4
`define AOC_WGT_LO         3
`define AOC_CAL_DONE_BIT   7
`define AOC_PLL_DONE_BIT   5
`define AOC_PLL_LOW_BIT    2
`define AOC_PLL_HIGH_BIT   1
`define AOC_PLL_LAUNCH_BIT 0
`define AOC_DSP_EN_BIT     0

// Interrupt status bits
`define AOC_EV_CAL_DONE    0
`define AOC_EV_PLL_DONE    1
`define AOC_EV_DRIFT_LOW   2
`define AOC_EV_DRIFT_HIGH  3
`define AOC_EV_BG_UPDATE   4
`define AOC_EV_W           5

// Bus responses
`define AOC_RESP_OKAY      2'b00
`define AOC_RESP_SLVERR    2'b10

// Calibration periods in sample clock cycles
`define AOC_CAL_CYCLES     32'd134217728
`define AOC_BG_CYCLES      32'd1073741824

// Pipeline latencies in cycles
`define AOC_BASE_LAT       4
`define AOC_DSP_LAT        2

`endif

// File: design/aoc_pipe.v
// Fixed-depth delay line for the sample path.
// Assumes DEPTH of one or more; every stage advances every clock.
`timescale 1ns/1ps
module aoc_pipe #(
  parameter W     = 16,
  parameter DEPTH = 4
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] stage_r [0:DEPTH-1];
  integer     i;

  // Shift one stage per clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        stage_r[i] <= {W{1'b0}};
      end
    end else begin
      stage_r[0] <= din;
      for (i = 1; i < DEPTH; i = i + 1) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign dout = stage_r[DEPTH-1];
endmodule

// File: design/aoc_regs.v
// Offset, calibration status and identity register bank with sample path.
// Assumes an AXI4-Lite master on clk and PLL status levels from pins.
`timescale 1ns/1ps
`include "aoc_defines.vh"
module aoc_regs #(
  parameter        DW          = 16,
  parameter [15:0] ID_CODE     = 16'h5a3c,  // Arbitrary value
  parameter [6:0]  CAL_RSVD    = 7'h00,     // Arbitrary filler
  parameter [4:0]  PLL_RSVD    = 5'h00,     // Arbitrary filler
  parameter [31:0] CAL_CYCLES  = `AOC_CAL_CYCLES,
  parameter [31:0] BG_CYCLES   = `AOC_BG_CYCLES,
  parameter        BASE_LAT    = `AOC_BASE_LAT,
  parameter        DSP_LAT     = `AOC_DSP_LAT
) (
  input  wire          clk,
  input  wire          rst,
  input  wire [11:0]   s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [11:0]   s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire [DW-1:0] sample_in,
  output reg  [DW-1:0] sample_out,
  input  wire          pll_cal_done_pin,
  input  wire          pll_drift_low_pin,
  input  wire          pll_drift_high_pin,
  output reg           pll_calibration_launch,
  output reg           bg_cal_update,
  output wire          adc_cal_done,
  output wire          irq
);
  localparam SW = DW + 2;  // Sample with two quarter-LSb bits

  // Write channel state
  reg        aw_have_r;
  reg [9:0]  aw_idx_r;
  reg        w_have_r;
  reg [31:0] wdata_r;
  reg        wlane0_r;
  // Control registers
  reg [7:0]  ch7_ofs_r;
  reg [7:0]  weight_r;
  reg        dsp_en_r;
  reg [`AOC_EV_W-1:0] irq_stat_r;
  reg [`AOC_EV_W-1:0] irq_stat_nxt;
  reg [`AOC_EV_W-1:0] irq_mask_r;
  reg        launch_pend_r;
  // Calibration state
  reg [31:0] cal_cnt_r;
  reg        cal_done_r;
  reg [31:0] bg_cnt_r;
  reg        cal_done_d_r;
  // Synchronised PLL status and edge history
  wire [2:0] pll_s;
  reg  [2:0] pll_d_r;
  // Read mux and write decode flag
  reg [31:0] rd_word;
  reg        rd_err;
  reg        wr_err;
  // Sample path
  reg  [DW-1:0] ofs_out_r;
  wire [DW-1:0] base_out;
  wire [DW-1:0] dsp_out;

  wire do_wr  = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire wr_en  = do_wr & wlane0_r;
  wire [7:0] wbyte = wdata_r[7:0];
  wire do_rd  = s_axi_arvalid & ~s_axi_rvalid;
  wire [9:0] ar_idx = s_axi_araddr[11:2];

  assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign adc_cal_done  = cal_done_r;

  // PLL status pins into the clock domain
  aoc_sync #(
    .W (3)
  ) u_pll_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({pll_cal_done_pin, pll_drift_low_pin, pll_drift_high_pin}),
    .dout (pll_s)
  );

  // Done flag is low while a launched calibration is pending
  wire pll_done_flag = pll_s[2] & ~launch_pend_r;

  // Address capture, either order
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      aw_idx_r  <= 10'h000;
      w_have_r  <= 1'b0;
      wdata_r   <= 32'h00000000;
      wlane0_r  <= 1'b0;
    end else if (do_wr) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wlane0_r <= s_axi_wstrb[0];
      end
    end
  end

  // Write decode: unmapped gets an error, read-only is ignored
  always @* begin
    case (aw_idx_r)
      `AOC_IDX_CH7_OFS,
      `AOC_IDX_WEIGHT,
      `AOC_IDX_CAL_STAT,
      `AOC_IDX_PLL_STAT,
      `AOC_IDX_ID_LO,
      `AOC_IDX_ID_HI,
      `AOC_IDX_PLL_CTRL,
      `AOC_IDX_DSP_CTRL,
      `AOC_IDX_IRQ_STAT,
      `AOC_IDX_IRQ_MASK: wr_err = 1'b0;
      default:           wr_err = 1'b1;
    endcase
  end

  // Write response
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AOC_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? `AOC_RESP_SLVERR : `AOC_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Writable registers; calibration and PLL status and identity ignore writes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ch7_ofs_r  <= `AOC_RST_CH7_OFS;
      weight_r   <= `AOC_RST_WEIGHT;
      dsp_en_r   <= 1'b0;
      irq_mask_r <= `AOC_RST_IRQ;
    end else if (wr_en) begin
      case (aw_idx_r)
        `AOC_IDX_CH7_OFS:  ch7_ofs_r  <= wbyte;
        `AOC_IDX_WEIGHT:   weight_r   <= wbyte;
        `AOC_IDX_DSP_CTRL: dsp_en_r   <= wbyte[`AOC_DSP_EN_BIT];
        `AOC_IDX_IRQ_MASK: irq_mask_r <= wbyte[`AOC_EV_W-1:0];
        default:           ch7_ofs_r  <= ch7_ofs_r;
      endcase
    end
  end

  // PLL launch pulse and pending tracker
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_calibration_launch <= 1'b0;
      launch_pend_r          <= 1'b0;
    end else begin
      pll_calibration_launch <= wr_en &&
        (aw_idx_r == `AOC_IDX_PLL_CTRL) &&
        wbyte[`AOC_PLL_LAUNCH_BIT];
      if (pll_calibration_launch) begin
        launch_pend_r <= 1'b1;
      end else if (!pll_s[2]) begin
        launch_pend_r <= 1'b0;  // PLL has restarted calibration
      end
    end
  end

  // Power-up calibration timer, flag sticky until reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_cnt_r  <= 32'h00000000;
      cal_done_r <= 1'b0;
    end else if (!cal_done_r) begin
      if (cal_cnt_r == CAL_CYCLES - 32'h00000001) begin
        cal_done_r <= 1'b1;
      end
      cal_cnt_r <= cal_cnt_r + 32'h00000001;
    end
  end

  // Background calibration update tick after power-up calibration
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bg_cnt_r      <= 32'h00000000;
      bg_cal_update <= 1'b0;
    end else begin
      bg_cal_update <= 1'b0;
      if (cal_done_r) begin
        if (bg_cnt_r == BG_CYCLES - 32'h00000001) begin
          bg_cnt_r      <= 32'h00000000;
          bg_cal_update <= 1'b1;
        end else begin
          bg_cnt_r <= bg_cnt_r + 32'h00000001;
        end
      end
    end
  end

  // Events for interrupt status, each a one-cycle rise
  wire [`AOC_EV_W-1:0] ev;
  // Done level never falls before reset, so only its rise is an event
  assign ev[`AOC_EV_CAL_DONE]   = cal_done_r & ~cal_done_d_r;
  assign ev[`AOC_EV_PLL_DONE]   = pll_done_flag & ~pll_d_r[2];
  assign ev[`AOC_EV_DRIFT_LOW]  = pll_s[1] & ~pll_d_r[1];
  assign ev[`AOC_EV_DRIFT_HIGH] = pll_s[0] & ~pll_d_r[0];
  assign ev[`AOC_EV_BG_UPDATE]  = bg_cal_update;

  // Sticky status, write one to clear, set wins
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (wr_en && (aw_idx_r == `AOC_IDX_IRQ_STAT)) begin
      irq_stat_nxt = irq_stat_nxt & ~wbyte[`AOC_EV_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | ev;
  end

  // Status and edge history registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_r   <= `AOC_RST_IRQ;
      pll_d_r      <= 3'b000;
      cal_done_d_r <= 1'b0;
    end else begin
      irq_stat_r   <= irq_stat_nxt;
      pll_d_r      <= {pll_done_flag, pll_s[1:0]};
      cal_done_d_r <= cal_done_r;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // Read data selection
  always @* begin
    rd_word = 32'h00000000;
    rd_err  = 1'b0;
    case (ar_idx)
      `AOC_IDX_CH7_OFS:  rd_word[7:0] = ch7_ofs_r;
      `AOC_IDX_WEIGHT:   rd_word[7:0] = weight_r;
      `AOC_IDX_CAL_STAT: rd_word[7:0] = {cal_done_r, CAL_RSVD};
      `AOC_IDX_PLL_STAT: rd_word[7:0] = {PLL_RSVD[4:3],
                                         pll_done_flag,
                                         PLL_RSVD[2:1],
                                         pll_s[1],
                                         pll_s[0],
                                         PLL_RSVD[0]};
      `AOC_IDX_ID_LO:    rd_word[7:0] = ID_CODE[7:0];
      `AOC_IDX_ID_HI:    rd_word[7:0] = ID_CODE[15:8];
      `AOC_IDX_PLL_CTRL: rd_word[7:0] = 8'h00;
      `AOC_IDX_DSP_CTRL: rd_word[0]   = dsp_en_r;
      `AOC_IDX_IRQ_STAT: rd_word[`AOC_EV_W-1:0] = irq_stat_r;
      `AOC_IDX_IRQ_MASK: rd_word[`AOC_EV_W-1:0] = irq_mask_r;
      default:           rd_err = 1'b1;
    endcase
  end

  // Read response, one cycle after the address
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `AOC_RESP_OKAY;
    end else if (do_rd) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_err ? `AOC_RESP_SLVERR : `AOC_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Offset in quarter-LSb units: signed code shifted by weight
  wire [1:0]  wsel    = weight_r[`AOC_WGT_HI:`AOC_WGT_LO];
  wire [10:0] ofs_ext = {{3{ch7_ofs_r[7]}}, ch7_ofs_r};
  wire [10:0] ofs_q   = ofs_ext << wsel;
  wire [SW-1:0] ofs_w = {{(SW-11){ofs_q[10]}}, ofs_q};
  wire [SW-1:0] acc   = {sample_in, 2'b00} + ofs_w;

  // Offset stage, fraction dropped toward minus infinity
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ofs_out_r <= {DW{1'b0}};
    end else begin
      ofs_out_r <= acc[SW-1:2];
    end
  end

  // Fixed conversion pipeline
  aoc_pipe #(
    .W     (DW),
    .DEPTH (BASE_LAT)
  ) u_base (
    .clk  (clk),
    .rst  (rst),
    .din  (ofs_out_r),
    .dout (base_out)
  );

  // Extra stages used with post-processing on
  aoc_pipe #(
    .W     (DW),
    .DEPTH (DSP_LAT)
  ) u_dsp (
    .clk  (clk),
    .rst  (rst),
    .din  (base_out),
    .dout (dsp_out)
  );

  // Output stage, new sample every clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_out <= {DW{1'b0}};
    end else begin
      sample_out <= dsp_en_r ? dsp_out : base_out;
    end
  end
endmodule

// File: design/aoc_sync.v
// Two-flop synchroniser for slowly changing status levels.
// Assumes each bit is a level, not a pulse, from another domain.
`timescale 1ns/1ps
module aoc_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_r;

  // First flop feeds only the second
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule
